// ### csc_pkg.sv
// Purpose: shared constants and types for clock source start-up control
// Assumes: fuse values are static while the block runs
// Notes: counts above 4096 live as top-level parameters instead
package csc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W = 17;
	localparam logic [3:0] ADDR_TRIM = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_SAVE_BIT = 1;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SRC_LSB = 3;
	localparam int STAT_DIV_BIT = 5;
	localparam int STAT_RSVD_BIT = 6;
	localparam logic FUSE_PROGRAMMED = 1'b0;
	localparam logic [3:0] SEL_EXT = 4'h0;
	localparam logic [3:0] SEL_RC = 4'h2;
	localparam logic [3:0] SEL_LF_LO = 4'h6;
	localparam logic [3:0] SEL_LF_HI = 4'h7;
	localparam logic [3:0] SEL_XTAL_LO = 4'h8;
	localparam logic [1:0] SUT_NONE = 2'h0;
	localparam logic [1:0] SUT_SHORT = 2'h1;
	localparam logic [16:0] CNT_ZERO = 17'h00000;
	localparam logic [16:0] CNT_ONE = 17'h00001;
	localparam logic [16:0] RST_SHORT_CYCLES = 17'h01000;
	localparam logic [16:0] RESET_CK_CYCLES = 17'h0000E;
	localparam logic [16:0] WAKE_RC_CYCLES = 17'h00006;
	localparam logic [16:0] WAKE_258_CYCLES = 17'h00102;
	localparam logic [16:0] WAKE_1K_CYCLES = 17'h00400;
	localparam logic [2:0] DIV_LAST = 3'h7;
	typedef enum logic [1:0] {
		SRC_CRYSTAL = 2'h0,
		SRC_LOWFREQ = 2'h1,
		SRC_RC = 2'h2,
		SRC_EXT = 2'h3
	} csc_source_type;
	typedef enum logic [2:0] {
		ST_LOAD = 3'h0,
		ST_RST_WDT = 3'h1,
		ST_RST_CK = 3'h3,
		ST_RUN = 3'h2,
		ST_SLEEP = 3'h6,
		ST_WAKE = 3'h7
	} csc_state_type;
	typedef struct packed {
		logic [3:0] clockSourceSelect;
		logic [1:0] startupTimeSelect;
		logic divideByEightFuse;
	} csc_fuse_type;
	localparam csc_fuse_type FUSE_DEFAULT = '{4'h2, 2'h2, 1'b0};
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wrData;
		logic wrStrobe;
		logic rdStrobe;
	} csc_bus_type;
endpackage

// ### csc_pin_sync.sv
// Purpose: bring an oscillator pin into the clock domain as a rise pulse
// Assumes: pin toggles well below half the system clock rate
// Notes: a change counts once the second and third stages agree
`timescale 1ns/10ps
module csc_pin_sync (
	input wire logic clock,
	input wire logic srst,
	input wire logic pinIn,
	output logic rise
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;
	logic rise_reg;
	logic rise_next;

	// stage 0 feeds only stage 1
	always_comb begin
		stage_next = {stage_reg[1:0], pinIn};
		level_next = level_reg;
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
		end
		rise_next = level_next & ~level_reg;
		if (srst) begin
			// track the pin through reset so release shows no false rise
			level_next = stage_reg[2];
			rise_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		stage_reg <= stage_next;
		level_reg <= level_next;
		rise_reg <= rise_next;
	end

	assign rise = rise_reg;
endmodule

// ### csc_startup_control.sv
// Purpose: clock source decode, start-up delays, trim and clock gating
// Assumes: oscillator pins are slow next to the 50 MHz system clock
// Notes: delays count source or watchdog ticks, never system cycles
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] decode source select into four source classes
// [R2] fuse bit zero means programmed, one unprogrammed
// [R3] wake delay counts selected source ticks first
// [R4] reset adds delay counted on watchdog ticks
// [R5] reset timeout is 4096 or 65536 watchdog ticks
// [R6] default fuses: rc source, longest delay, divide
// [R7] trim register loads factory value during reset
// [R8] software may overwrite the trim register
// [R9] watchdog ticks time reset even with rc
// [R10] rc: six tick wake, 14 tick reset tail
// [R11] programmed divide fuse gives one tick in eight
// [R12] async timer clock survives power-save sleep
// [R13] converter clock runs while a conversion is busy
// [R14] flash clock gates together with cpu clock
// [R15] core clocks stay gated until delay expires
module csc_startup_control #(
	parameter logic [16:0] WAKE_16K_CYCLES = 17'h04000,
	parameter logic [16:0] WAKE_32K_CYCLES = 17'h08000,
	parameter logic [16:0] RST_LONG_CYCLES = 17'h10000
) (
	input wire logic clock,
	input wire logic srst,
	input csc_pkg::csc_bus_type busReq,
	output logic [7:0] rdData,
	input csc_pkg::csc_fuse_type fuses,
	input wire logic [7:0] factoryTrim,
	input wire logic watchdogOscIn,
	input wire logic sourceOscIn,
	input wire logic wakeEvent,
	input wire logic conversionBusy,
	output logic cpuClockEnable,
	output logic ioClockEnable,
	output logic flashInterfaceClockEnable,
	output logic asyncTimerClockEnable,
	output logic converterClockEnable,
	output logic coreTick,
	output logic [7:0] oscillatorTrim
);
	csc_pkg::csc_state_type state_reg;
	csc_pkg::csc_state_type state_next;
	csc_pkg::csc_fuse_type fuse_reg;
	csc_pkg::csc_fuse_type fuse_next;
	csc_pkg::csc_source_type source;
	logic [16:0] cnt_reg;
	logic [16:0] cnt_next;
	logic [16:0] wakeTarget;
	logic [16:0] resetTarget;
	logic [7:0] trim_reg;
	logic [7:0] trim_next;
	logic powerSave_reg;
	logic powerSave_next;
	logic [7:0] rdData_reg;
	logic [7:0] rdData_next;
	logic [2:0] div_reg;
	logic [2:0] div_next;
	logic prescale_reg;
	logic prescale_next;
	logic cpuEn_reg;
	logic cpuEn_next;
	logic flashEn_reg;
	logic ioEn_reg;
	logic asyncEn_reg;
	logic asyncEn_next;
	logic convEn_reg;
	logic convEn_next;
	logic tick_reg;
	logic tick_next;
	logic wdtTick;
	logic srcTick;
	logic sleepCmd;
	logic reservedCode;
	logic ctrlWrite;

	function automatic csc_pkg::csc_source_type decodeSource(
		input logic [3:0] sel);
		if (sel >= csc_pkg::SEL_XTAL_LO) begin
			return csc_pkg::SRC_CRYSTAL;
		end else if (sel == csc_pkg::SEL_LF_LO || sel == csc_pkg::SEL_LF_HI) begin
			return csc_pkg::SRC_LOWFREQ;
		end else if (sel == csc_pkg::SEL_EXT) begin
			return csc_pkg::SRC_EXT;
		end
		// reserved codes fall back to the rc oscillator
		return csc_pkg::SRC_RC;
	endfunction

	function automatic logic isReserved(input logic [3:0] sel);
		return sel < csc_pkg::SEL_LF_LO && sel != csc_pkg::SEL_RC
			&& sel != csc_pkg::SEL_EXT;
	endfunction

	csc_pin_sync u_wdtSync (
		.clock(clock),
		.srst(srst),
		.pinIn(watchdogOscIn),
		.rise(wdtTick)
	);

	csc_pin_sync u_srcSync (
		.clock(clock),
		.srst(srst),
		.pinIn(sourceOscIn),
		.rise(srcTick)
	);

	assign source = decodeSource(fuse_reg.clockSourceSelect); // [R1]
	assign reservedCode = isReserved(fuse_reg.clockSourceSelect); // [R1]
	assign ctrlWrite = busReq.wrStrobe && busReq.addr == csc_pkg::ADDR_CONTROL;
	assign sleepCmd = ctrlWrite && busReq.wrData[csc_pkg::CTRL_SLEEP_BIT];

	// wake delay in ticks of the selected source
	always_comb begin
		wakeTarget = csc_pkg::WAKE_RC_CYCLES; // [R10]
		unique case (source)
			csc_pkg::SRC_CRYSTAL: begin
				if (!fuse_reg.clockSourceSelect[0]
					&& !fuse_reg.startupTimeSelect[1]) begin
					wakeTarget = csc_pkg::WAKE_258_CYCLES;
				end else if (!fuse_reg.clockSourceSelect[0]
					|| fuse_reg.startupTimeSelect == csc_pkg::SUT_NONE) begin
					wakeTarget = csc_pkg::WAKE_1K_CYCLES;
				end else begin
					wakeTarget = WAKE_16K_CYCLES;
				end
			end
			csc_pkg::SRC_LOWFREQ: begin
				wakeTarget = fuse_reg.clockSourceSelect[0] ?
					WAKE_32K_CYCLES : csc_pkg::WAKE_1K_CYCLES;
			end
			csc_pkg::SRC_RC, csc_pkg::SRC_EXT: begin
				wakeTarget = csc_pkg::WAKE_RC_CYCLES; // [R10]
			end
		endcase
	end

	// extra reset delay in watchdog ticks
	always_comb begin
		resetTarget = RST_LONG_CYCLES;
		if (source == csc_pkg::SRC_CRYSTAL) begin
			unique case ({fuse_reg.clockSourceSelect[0],
				fuse_reg.startupTimeSelect})
				3'h0, 3'h3, 3'h6: resetTarget = csc_pkg::RST_SHORT_CYCLES;
				3'h1, 3'h4, 3'h7: resetTarget = RST_LONG_CYCLES;
				3'h2, 3'h5: resetTarget = csc_pkg::CNT_ZERO;
			endcase
		end else if (fuse_reg.startupTimeSelect == csc_pkg::SUT_NONE) begin
			resetTarget = csc_pkg::CNT_ZERO; // [R10]
		end else if (fuse_reg.startupTimeSelect == csc_pkg::SUT_SHORT) begin
			resetTarget = csc_pkg::RST_SHORT_CYCLES; // [R5]
		end
		// reserved setting 11 takes the longest delay as the safe choice
	end

	// start-up sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		fuse_next = fuse_reg;
		unique case (state_reg)
			csc_pkg::ST_LOAD: begin
				fuse_next = fuses;
				cnt_next = csc_pkg::CNT_ZERO;
				state_next = csc_pkg::ST_RST_WDT;
			end
			csc_pkg::ST_RST_WDT: begin
				if (resetTarget == csc_pkg::CNT_ZERO) begin
					state_next = csc_pkg::ST_RST_CK;
				end else if (wdtTick) begin // [R4] [R9]
					cnt_next = cnt_reg + csc_pkg::CNT_ONE;
					if (cnt_reg == resetTarget - csc_pkg::CNT_ONE) begin // [R5]
						cnt_next = csc_pkg::CNT_ZERO;
						state_next = csc_pkg::ST_RST_CK;
					end
				end
			end
			csc_pkg::ST_RST_CK: begin
				if (srcTick) begin
					cnt_next = cnt_reg + csc_pkg::CNT_ONE;
					if (cnt_reg == csc_pkg::RESET_CK_CYCLES - csc_pkg::CNT_ONE)
					begin // [R10]
						cnt_next = csc_pkg::CNT_ZERO;
						state_next = csc_pkg::ST_RUN;
					end
				end
			end
			csc_pkg::ST_RUN: begin
				if (sleepCmd) begin
					state_next = csc_pkg::ST_SLEEP;
				end
			end
			csc_pkg::ST_SLEEP: begin
				if (wakeEvent) begin
					cnt_next = csc_pkg::CNT_ZERO;
					state_next = csc_pkg::ST_WAKE;
				end
			end
			csc_pkg::ST_WAKE: begin
				if (srcTick) begin // [R3]
					cnt_next = cnt_reg + csc_pkg::CNT_ONE;
					if (cnt_reg == wakeTarget - csc_pkg::CNT_ONE) begin
						cnt_next = csc_pkg::CNT_ZERO;
						state_next = csc_pkg::ST_RUN;
					end
				end
			end
			default: begin
				state_next = csc_pkg::ST_LOAD;
			end
		endcase
		if (srst) begin
			state_next = csc_pkg::ST_LOAD;
			cnt_next = csc_pkg::CNT_ZERO;
			fuse_next = csc_pkg::FUSE_DEFAULT; // [R6]
		end
	end

	// software registers
	always_comb begin
		trim_next = trim_reg;
		powerSave_next = powerSave_reg;
		rdData_next = 8'h00;
		if (busReq.wrStrobe && busReq.addr == csc_pkg::ADDR_TRIM) begin
			trim_next = busReq.wrData; // [R8]
		end
		if (ctrlWrite) begin
			powerSave_next = busReq.wrData[csc_pkg::CTRL_SAVE_BIT];
		end
		if (busReq.rdStrobe) begin
			unique case (busReq.addr)
				csc_pkg::ADDR_TRIM: rdData_next = trim_reg;
				csc_pkg::ADDR_CONTROL: begin
					rdData_next[csc_pkg::CTRL_SAVE_BIT] = powerSave_reg;
				end
				csc_pkg::ADDR_STATUS: begin
					rdData_next[csc_pkg::STAT_STATE_LSB +: 3] = state_reg;
					rdData_next[csc_pkg::STAT_SRC_LSB +: 2] = source;
					rdData_next[csc_pkg::STAT_DIV_BIT] = prescale_reg;
					rdData_next[csc_pkg::STAT_RSVD_BIT] = reservedCode;
				end
				default: rdData_next = 8'h00;
			endcase
		end
		if (srst) begin
			// reload every reset, so a warm reset drops software tuning
			trim_next = factoryTrim; // [R7]
			powerSave_next = 1'b0;
			rdData_next = 8'h00;
		end
	end

	// clock gates and divided core tick
	always_comb begin
		prescale_next = fuse_reg.divideByEightFuse == csc_pkg::FUSE_PROGRAMMED; // [R2]
		cpuEn_next = state_next == csc_pkg::ST_RUN; // [R15]
		asyncEn_next = cpuEn_next || powerSave_next; // [R12]
		convEn_next = cpuEn_next || conversionBusy; // [R13]
		div_next = div_reg;
		tick_next = 1'b0;
		if (state_reg == csc_pkg::ST_RUN && srcTick) begin
			div_next = div_reg + 3'h1;
			tick_next = !prescale_reg || div_reg == csc_pkg::DIV_LAST; // [R11]
		end
		if (srst) begin
			prescale_next = 1'b0;
			cpuEn_next = 1'b0;
			asyncEn_next = 1'b0;
			convEn_next = 1'b0;
			div_next = 3'h0;
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		fuse_reg <= fuse_next;
		trim_reg <= trim_next;
		powerSave_reg <= powerSave_next;
		rdData_reg <= rdData_next;
		prescale_reg <= prescale_next;
		cpuEn_reg <= cpuEn_next;
		flashEn_reg <= cpuEn_next; // [R14]
		ioEn_reg <= cpuEn_next;
		asyncEn_reg <= asyncEn_next;
		convEn_reg <= convEn_next;
		div_reg <= div_next;
		tick_reg <= tick_next;
	end

	assign rdData = rdData_reg;
	assign cpuClockEnable = cpuEn_reg;
	assign ioClockEnable = ioEn_reg;
	assign flashInterfaceClockEnable = flashEn_reg;
	assign asyncTimerClockEnable = asyncEn_reg;
	assign converterClockEnable = convEn_reg;
	assign coreTick = tick_reg;
	assign oscillatorTrim = trim_reg;

	sequence s_wakeEntry;
		state_reg == csc_pkg::ST_SLEEP ##1 state_reg == csc_pkg::ST_WAKE;
	endsequence

	property p_decodeRc;
		@(posedge clock) disable iff (srst)
		(state_reg != csc_pkg::ST_LOAD
			&& fuse_reg.clockSourceSelect == csc_pkg::SEL_RC)
			|-> source == csc_pkg::SRC_RC && !reservedCode;
	endproperty
	a_decodeRc: assert property (p_decodeRc) else $error("bad decode"); // [R1]

	property p_unprogrammed;
		@(posedge clock) disable iff (srst)
		(state_reg == csc_pkg::ST_RUN && fuse_reg.divideByEightFuse)
			##1 (state_reg == csc_pkg::ST_RUN) |-> !prescale_reg;
	endproperty
	a_unprogrammed: assert property (p_unprogrammed) else $error("div on"); // [R2]

	property p_wakeGated;
		@(posedge clock) disable iff (srst)
		s_wakeEntry |-> !cpuClockEnable && !flashInterfaceClockEnable;
	endproperty
	a_wakeGated: assert property (p_wakeGated) else $error("early run"); // [R3]

	property p_wdtOnly;
		@(posedge clock) disable iff (srst)
		(state_reg == csc_pkg::ST_RST_WDT && !wdtTick
			&& resetTarget != csc_pkg::CNT_ZERO) |=> $stable(cnt_reg);
	endproperty
	a_wdtOnly: assert property (p_wdtOnly) else $error("no wdt tick"); // [R4]

	property p_resetLength;
		@(posedge clock) disable iff (srst)
		(state_reg == csc_pkg::ST_RST_WDT
			&& state_next == csc_pkg::ST_RST_CK)
			|-> resetTarget == csc_pkg::CNT_ZERO
			|| (wdtTick && cnt_reg == resetTarget - csc_pkg::CNT_ONE);
	endproperty
	a_resetLength: assert property (p_resetLength) else $error("timeout"); // [R5]

	property p_defaultFuses;
		@(posedge clock) $fell(srst) |-> fuse_reg == csc_pkg::FUSE_DEFAULT;
	endproperty
	a_defaultFuses: assert property (p_defaultFuses) else $error("dflt"); // [R6]

	property p_trimLoad;
		@(posedge clock) $fell(srst) |-> trim_reg == $past(factoryTrim);
	endproperty
	a_trimLoad: assert property (p_trimLoad) else $error("trim load"); // [R7]

	property p_trimWrite;
		@(posedge clock) disable iff (srst)
		(busReq.wrStrobe && busReq.addr == csc_pkg::ADDR_TRIM)
			|=> oscillatorTrim == $past(busReq.wrData);
	endproperty
	a_trimWrite: assert property (p_trimWrite) else $error("trim wr"); // [R8]

	property p_rcWdt;
		@(posedge clock) disable iff (srst)
		(source == csc_pkg::SRC_RC && state_reg == csc_pkg::ST_RST_WDT
			&& wdtTick && state_next == csc_pkg::ST_RST_WDT)
			|=> cnt_reg == $past(cnt_reg) + csc_pkg::CNT_ONE;
	endproperty
	a_rcWdt: assert property (p_rcWdt) else $error("rc wdt"); // [R9]

	property p_rcWake;
		@(posedge clock) disable iff (srst)
		(source == csc_pkg::SRC_RC && state_reg == csc_pkg::ST_WAKE
			&& state_next == csc_pkg::ST_RUN)
			|-> cnt_reg == csc_pkg::WAKE_RC_CYCLES - csc_pkg::CNT_ONE;
	endproperty
	a_rcWake: assert property (p_rcWake) else $error("rc wake"); // [R10]

	property p_divide;
		@(posedge clock) disable iff (srst)
		(coreTick && prescale_reg) |-> $past(div_reg) == csc_pkg::DIV_LAST;
	endproperty
	a_divide: assert property (p_divide) else $error("div8"); // [R11]

	property p_asyncSleep;
		@(posedge clock) disable iff (srst)
		(state_reg == csc_pkg::ST_SLEEP && powerSave_reg)[*2]
			|-> asyncTimerClockEnable && !cpuClockEnable;
	endproperty
	a_asyncSleep: assert property (p_asyncSleep) else $error("async"); // [R12]

	property p_converter;
		@(posedge clock) disable iff (srst)
		conversionBusy |=> converterClockEnable;
	endproperty
	a_converter: assert property (p_converter) else $error("conv"); // [R13]

	property p_flash;
		@(posedge clock) disable iff (srst)
		flashInterfaceClockEnable == cpuClockEnable;
	endproperty
	a_flash: assert property (p_flash) else $error("flash gate"); // [R14]

	property p_gateRun;
		@(posedge clock) disable iff (srst)
		cpuClockEnable == (state_reg == csc_pkg::ST_RUN);
	endproperty
	a_gateRun: assert property (p_gateRun) else $error("gate"); // [R15]
endmodule

// ### csc_osc_model.sv
// Purpose: free-running oscillator pin seen at the block's far side
// Assumes: half period is several system cycles, phase unrelated to clock
// Notes: runs through reset and sleep, as a real crystal or rc would
`timescale 1ns/10ps
module csc_osc_model #(
	parameter realtime HALF_NS = 90.0,
	parameter realtime PHASE_NS = 7.3
) (
	output logic oscOut
);
	// odd phase offset keeps pin edges away from the system clock edge
	initial begin
		oscOut = 1'b0;
		#PHASE_NS;
		forever begin
			#HALF_NS oscOut = ~oscOut;
		end
	end
endmodule

// ### clock_source_startup_control_bench.sv
// Purpose: self-checking bench for clock source start-up control
// Assumes: shortened long counts, free-running oscillator models
// Notes: tick counts allow a few cycles of synchroniser slack
`timescale 1ns/10ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errorCnt++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module clock_source_startup_control_bench;
	logic clock;
	logic srst;
	csc_pkg::csc_bus_type busReq;
	logic [7:0] rdData;
	csc_pkg::csc_fuse_type fuses;
	logic [7:0] factoryTrim;
	logic watchdogOscIn;
	logic sourceOscIn;
	logic wakeEvent;
	logic conversionBusy;
	logic cpuEn, ioEn, flashEn, asyEn, convEn, coreTick;
	logic [7:0] oscillatorTrim;
	logic [7:0] rd;
	int errorCnt = 0;
	int nChecks = 0;
	int wdCnt = 0;
	int srcCnt = 0;
	int cycCnt = 0;
	logic [3:0] codes [7] = '{4'h0, 4'h2, 4'h6, 4'h7, 4'h8, 4'hF, 4'h3};
	logic [1:0] srcExp [7] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
	logic rsvdExp [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	csc_startup_control #(
		.WAKE_16K_CYCLES(17'h00010),
		.WAKE_32K_CYCLES(17'h00010),
		.RST_LONG_CYCLES(17'h00020)
	) csc_startup_control_inst (
		.clock(clock),
		.srst(srst),
		.busReq(busReq),
		.rdData(rdData),
		.fuses(fuses),
		.factoryTrim(factoryTrim),
		.watchdogOscIn(watchdogOscIn),
		.sourceOscIn(sourceOscIn),
		.wakeEvent(wakeEvent),
		.conversionBusy(conversionBusy),
		.cpuClockEnable(cpuEn),
		.ioClockEnable(ioEn),
		.flashInterfaceClockEnable(flashEn),
		.asyncTimerClockEnable(asyEn),
		.converterClockEnable(convEn),
		.coreTick(coreTick),
		.oscillatorTrim(oscillatorTrim)
	);
	csc_osc_model #(.HALF_NS(110.0), .PHASE_NS(3.1)) wd_osc_inst (
		.oscOut(watchdogOscIn)
	);
	csc_osc_model #(.HALF_NS(90.0), .PHASE_NS(7.3)) src_osc_inst (
		.oscOut(sourceOscIn)
	);

	initial begin
		clock = 1'b0;
		forever begin
			#10 clock = ~clock;
		end
	end
	always @(posedge watchdogOscIn) wdCnt++;
	always @(posedge sourceOscIn) srcCnt++;

	task give_verdict();
		$display("checks %0d mismatches %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// hang guard: whole run needs well under this many cycles
	always @(posedge clock) begin
		cycCnt++;
		if (cycCnt == 40000) begin
			errorCnt++;
			$display("[FAIL] t=%0t timeout", $time);
			give_verdict();
		end
	end

	task busWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		busReq.addr <= a;
		busReq.wrData <= d;
		busReq.wrStrobe <= 1'b1;
		@(posedge clock);
		busReq.wrStrobe <= 1'b0;
		@(posedge clock);
	endtask

	// read data stand only in the cycle after the strobe
	task busRead(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		busReq.addr <= a;
		busReq.rdStrobe <= 1'b1;
		@(posedge clock);
		busReq.rdStrobe <= 1'b0;
		#1 d = rdData;
		@(posedge clock);
	endtask

	task doReset(input csc_pkg::csc_fuse_type f);
		@(posedge clock);
		fuses <= f;
		srst <= 1'b1;
		repeat (9) @(posedge clock);
		// pin rises this close to release are still in the synchroniser
		wdCnt = 0;
		srcCnt = 0;
		@(posedge clock);
		#1 `CHK(oscillatorTrim, factoryTrim)
		`CHK(cpuEn, 1'b0)
		@(posedge clock);
		srst <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	task waitRun();
		int n;
		n = 0;
		while (cpuEn !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		#1 `CHK(cpuEn, 1'b1)
	endtask

	// count core ticks across n source rises
	task countTicks(input int n, input int lo, input int hi);
		int t;
		t = 0;
		srcCnt = 0;
		while (srcCnt < n) begin
			@(posedge clock);
			#1 if (coreTick === 1'b1) t++;
		end
		`CHK(t >= lo && t <= hi, 1'b1)
	endtask

	initial begin
		srst = 1'b1;
		busReq = '0;
		fuses = csc_pkg::FUSE_DEFAULT;
		factoryTrim = 8'h5C;
		wakeEvent = 1'b0;
		conversionBusy = 1'b0;
		@(posedge clock);
		doReset(csc_pkg::FUSE_DEFAULT);
		busRead(csc_pkg::ADDR_STATUS, rd);
		`CHK(rd[2:0], 3'h1)
		`CHK(rd[4:3], 2'h2)
		`CHK(rd[5], 1'b1)
		waitRun();
		`CHK(wdCnt >= 32, 1'b1)
		`CHK(srcCnt >= 14, 1'b1)
		`CHK({ioEn, flashEn}, 2'h3)
		countTicks(64, 7, 9);
		$display("test reset_default done");
		busWrite(csc_pkg::ADDR_TRIM, 8'hA5);
		`CHK(oscillatorTrim, 8'hA5)
		busRead(csc_pkg::ADDR_TRIM, rd);
		`CHK(rd, 8'hA5)
		busRead(4'hF, rd);
		`CHK(rd, 8'h00)
		$display("test trim done");
		conversionBusy <= 1'b1;
		busWrite(csc_pkg::ADDR_CONTROL, 8'h03);
		#1 `CHK({cpuEn, ioEn, flashEn}, 3'h0)
		`CHK(asyEn, 1'b1)
		`CHK(convEn, 1'b1)
		busRead(csc_pkg::ADDR_STATUS, rd);
		`CHK(rd[2:0], 3'h6)
		conversionBusy <= 1'b0;
		repeat (3) @(posedge clock);
		#1 `CHK(convEn, 1'b0)
		@(posedge clock);
		srcCnt = 0;
		repeat (3) @(posedge clock);
		wakeEvent <= 1'b1;
		@(posedge clock);
		wakeEvent <= 1'b0;
		waitRun();
		`CHK(srcCnt >= 6 && srcCnt <= 8, 1'b1)
		$display("test sleep_wake done");
		doReset('{4'h0, 2'h0, 1'b1});
		`CHK(oscillatorTrim, 8'h5C)
		waitRun();
		`CHK(srcCnt >= 14 && srcCnt <= 16, 1'b1)
		countTicks(16, 15, 17);
		$display("test external_clock done");
		for (int i = 0; i < 7; i++) begin
			doReset('{codes[i], 2'h0, 1'b1});
			busRead(csc_pkg::ADDR_STATUS, rd);
			`CHK(rd[4:3], srcExp[i])
			`CHK(rd[6], rsvdExp[i])
			`CHK(rd[5], 1'b0)
		end
		$display("test source_decode done");
		give_verdict();
	end
endmodule
